// >>> hw/fcsr_defs.svh
// Purpose: Offsets, fields, reset values and timing counts
// Assumes: 10 MHz system clock
// Notes:   Definitions only
`ifndef FCSR_DEFS_SVH
`define FCSR_DEFS_SVH

// ****************************************
// Command codes
// ****************************************
`define FCSR_CMD_SETUP    8'h04
`define FCSR_CMD_FLAGS    8'h05
`define FCSR_CMD_DUTY     8'h06

// ****************************************
// Setup register fields
// ****************************************
`define FCSR_SETUP_RST    8'h0a
`define FCSR_B_FCLR       7
`define FCSR_B_RES        6
`define FCSR_B_DSRC       5
`define FCSR_B_FAN2_PULSES_PER_REV_HI   4
`define FCSR_B_FAN2_PULSES_PER_REV_LO   3
`define FCSR_B_FAN1_PULSES_PER_REV_HI   2
`define FCSR_B_FAN1_PULSES_PER_REV_LO   1
`define FCSR_B_SHDN       0

// ****************************************
// Flags register fields
// ****************************************
`define FCSR_B_OTF        5
`define FCSR_B_OVF2       4
`define FCSR_B_OVF1       3
`define FCSR_B_VOPEN      2
`define FCSR_B_FLT2       1
`define FCSR_B_FLT1       0

// ****************************************
// Duty and speed values
// ****************************************
`define FCSR_DUTY_RST     4'h2
`define FCSR_SPEED_MAX    10'h1ff
`define FCSR_PWM_PERIOD   9'h12c
`define FCSR_PWM_BASE     9'h05a
`define FCSR_PWM_STEP     9'h00e

// ****************************************
// Timing
// ****************************************
`define FCSR_CLK_HZ       10000000
`define FCSR_FAULT_MS     2400
`define FCSR_FAULT_CYC    (`FCSR_FAULT_MS * (`FCSR_CLK_HZ / 1000))

`endif

// >>> hw/fcsr_pkg.sv
// Purpose: Types shared by the fan register block
// Assumes: Constants live in fcsr_defs.svh
// Notes:   None
package fcsr_pkg;

  typedef enum logic [2:0] {
    PU_FILL1 = 3'b001,
    PU_FILL2 = 3'b010,
    PU_RUN   = 3'b100
  } fcsr_pu_e;

  typedef logic [3:0] fcsr_duty_t;
  typedef logic [9:0] fcsr_raw_t;

endpackage

// >>> hw/fcsr_fault_timer.sv
// Purpose: Qualifies a low fan speed over a long window
// Assumes: below is a same-clock level
// Notes:   qual_r rises once below held longer than QUAL_CYCLES
`timescale 1ns/1ns
`include "fcsr_defs.svh"
module fcsr_fault_timer
  import fcsr_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES = `FCSR_FAULT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  input  wire logic below,
  output logic      qual_r
);
  localparam logic [24:0] QUAL_C = 25'(QUAL_CYCLES);

  logic [24:0] cnt_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 25'h0;
    end else if (!run || !below) begin
      cnt_r <= 25'h0;
    end else if (cnt_r < QUAL_C) begin
      cnt_r <= cnt_r + 25'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qual_r <= 1'b0;
    end else begin
      qual_r <= run && below && (cnt_r >= QUAL_C);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  qual_window_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(qual_r) |-> $past(cnt_r) == QUAL_C)
    else $error("fault qualified before window ran out");
endmodule

// >>> hw/fcsr_pwm_gen.sv
// Purpose: Fan drive pulse width from a 4-bit duty code
// Assumes: Period of 300 counts, one count per clock
// Notes:   Code 0 gives 90 counts high, each step adds 14
`timescale 1ns/1ns
`include "fcsr_defs.svh"
module fcsr_pwm_gen
  import fcsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire fcsr_duty_t duty_code,
  output logic            pwm_r
);
  logic [8:0] cnt_r;
  logic [8:0] on_cnt;

  // Linear 30% to 100% map
  assign on_cnt = `FCSR_PWM_BASE + 9'(duty_code) * `FCSR_PWM_STEP;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 9'h0;
    end else if (cnt_r == `FCSR_PWM_PERIOD - 9'h1) begin
      cnt_r <= 9'h0;
    end else begin
      cnt_r <= cnt_r + 9'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= enable && (cnt_r < on_cnt);
    end
  end
endmodule

// >>> hw/fcsr_regs.sv
// Purpose: Setup, flags and duty registers of a dual fan controller
// Assumes: Serial engine gives command, data and strobes on clk
// Notes:   Analog pins pass two flops before use
`timescale 1ns/1ns
`include "fcsr_defs.svh"
module fcsr_regs
  import fcsr_pkg::*;
#(
  parameter int unsigned FAULT_QUAL_CYCLES = `FCSR_FAULT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_cmd,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_r,
  input  wire logic       vin_over_pin,
  input  wire logic       vin_open_pin,
  input  wire fcsr_duty_t vin_duty_pin,
  input  wire fcsr_raw_t  fan1_speed_raw,
  input  wire fcsr_raw_t  fan2_speed_raw,
  input  wire logic [7:0] fan1_speed_threshold,
  input  wire logic [7:0] fan2_speed_threshold,
  output logic [8:0]      fan1_speed_reading_r,
  output logic [8:0]      fan2_speed_reading_r,
  output logic [3:0]      fan1_pulses_r,
  output logic [3:0]      fan2_pulses_r,
  output logic            shutdown_r,
  output logic            pwm_drive_r,
  output logic            alert_n_r
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] setup_r;
  fcsr_duty_t duty_r;
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [3:0] vduty_prev_r;
  fcsr_duty_t vduty_r;
  fcsr_pu_e   pu_r;
  logic       otf_r;
  logic       vopen_r;
  logic [1:0] ovf_r;
  logic [1:0] flt_r;
  logic [1:0] flt_nxt;
  logic [1:0] qual;
  logic [1:0] below;
  fcsr_raw_t  raw [2];
  logic [7:0] thr [2];
  logic [8:0] rep [2];
  logic       clr_pulse;
  logic       run;
  fcsr_duty_t duty_sel;
  logic [7:0] flags;
  logic       wr_setup;
  logic       wr_duty;

  assign raw[0] = fan1_speed_raw;
  assign raw[1] = fan2_speed_raw;
  assign thr[0] = fan1_speed_threshold;
  assign thr[1] = fan2_speed_threshold;

  assign wr_setup = reg_wr && (reg_cmd == `FCSR_CMD_SETUP);
  assign wr_duty  = reg_wr && (reg_cmd == `FCSR_CMD_DUTY);

  // Fresh request on every write with the bit set
  assign clr_pulse = wr_setup && reg_wdata[`FCSR_B_FCLR];

  assign run = (pu_r == PU_RUN) && !setup_r[`FCSR_B_SHDN];

  // ****************************************
  // Writable registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_r <= `FCSR_SETUP_RST;
    end else if (wr_setup) begin
      setup_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      duty_r <= `FCSR_DUTY_RST;
    end else if (wr_duty) begin
      duty_r <= reg_wdata[3:0];
    end
  end

  // Flags register takes no writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_cmd)
        `FCSR_CMD_SETUP: reg_rdata_r <= setup_r;
        `FCSR_CMD_FLAGS: reg_rdata_r <= flags;
        `FCSR_CMD_DUTY:  reg_rdata_r <= {4'h0, duty_r};
        default:         reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // No reset: real pin levels are in place before power-up capture
  always_ff @(posedge clk) begin
    pin_s1_r <= {vin_over_pin, vin_open_pin, vin_duty_pin};
    pin_s2_r <= pin_s1_r;
  end

  // Analog code taken only when two samples agree, so no torn word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vduty_prev_r <= 4'h0;
      vduty_r      <= `FCSR_DUTY_RST;
    end else begin
      vduty_prev_r <= pin_s2_r[3:0];
      if (pin_s2_r[3:0] == vduty_prev_r) begin
        vduty_r <= vduty_prev_r;
      end
    end
  end

  // ****************************************
  // Power-up capture
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_r <= PU_FILL1;
    end else begin
      case (pu_r)
        PU_FILL1: pu_r <= PU_FILL2;
        PU_FILL2: pu_r <= PU_RUN;
        PU_RUN:   pu_r <= PU_RUN;
        default:  pu_r <= PU_FILL1;
      endcase
    end
  end

  // Caught once the synchroniser holds real pin levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otf_r   <= 1'b0;
      vopen_r <= 1'b0;
    end else if (pu_r == PU_FILL2) begin
      otf_r   <= pin_s2_r[5];
      vopen_r <= pin_s2_r[4];
    end
  end

  // ****************************************
  // Per-fan speed, overflow and fault
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_fan
    // Raw count is in 25 RPM units
    assign rep[i] = setup_r[`FCSR_B_RES] ? raw[i][8:0]
                                         : {1'b0, raw[i][8:1]};
    assign below[i] = raw[i] < {1'b0, thr[i], 1'b0};

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        ovf_r[i] <= 1'b0;
      end else begin
        ovf_r[i] <= raw[i] > `FCSR_SPEED_MAX;
      end
    end

    fcsr_fault_timer #(
      .QUAL_CYCLES (FAULT_QUAL_CYCLES)
    ) u_timer (
      .clk    (clk),
      .rst_b  (rst_b),
      .run    (run),
      .below  (below[i]),
      .qual_r (qual[i])
    );

    // Set wins over clear; no self clear on recovery
    assign flt_nxt[i] = qual[i] || (flt_r[i] && !clr_pulse);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan1_speed_reading_r <= 9'h000;
      fan2_speed_reading_r <= 9'h000;
    end else begin
      fan1_speed_reading_r <= rep[0];
      fan2_speed_reading_r <= rep[1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flt_r     <= 2'b00;
      alert_n_r <= 1'b1;
    end else begin
      flt_r     <= flt_nxt;
      alert_n_r <= ~(|flt_nxt);
    end
  end

  assign flags = {2'b00, otf_r, ovf_r[1], ovf_r[0], vopen_r, flt_r};

  // ****************************************
  // Pulses per revolution
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan1_pulses_r <= 4'h2;
      fan2_pulses_r <= 4'h2;
    end else begin
      fan1_pulses_r <= 4'h1 << setup_r[`FCSR_B_FAN1_PULSES_PER_REV_HI:`FCSR_B_FAN1_PULSES_PER_REV_LO];
      fan2_pulses_r <= 4'h1 << setup_r[`FCSR_B_FAN2_PULSES_PER_REV_HI:`FCSR_B_FAN2_PULSES_PER_REV_LO];
    end
  end

  // ****************************************
  // Duty source and drive
  // ****************************************
  always_comb begin
    if (setup_r[`FCSR_B_DSRC]) begin
      duty_sel = duty_r;
    end else if (vopen_r) begin
      duty_sel = `FCSR_DUTY_RST;
    end else begin
      duty_sel = vduty_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_r <= 1'b0;
    end else begin
      shutdown_r <= setup_r[`FCSR_B_SHDN];
    end
  end

  fcsr_pwm_gen u_pwm (
    .clk       (clk),
    .rst_b     (rst_b),
    .enable    (run),
    .duty_code (duty_sel),
    .pwm_r     (pwm_drive_r)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  fault_clear_a: assert property (
    clr_pulse && !(|qual) |=> flt_r == 2'b00 && alert_n_r)
    else $error("fault clear did not clear flags");

  res_report_a: assert property (
    1'b1 |=> fan1_speed_reading_r ==
      ($past(setup_r[`FCSR_B_RES]) ? $past(raw[0][8:0])
                                   : {1'b0, $past(raw[0][8:1])}))
    else $error("speed report resolution wrong");

  prog_duty_a: assert property (
    setup_r[`FCSR_B_DSRC] |-> duty_sel == duty_r)
    else $error("programmed duty not used");

  open_duty_a: assert property (
    !setup_r[`FCSR_B_DSRC] && vopen_r |-> duty_sel == 4'h2)
    else $error("open input duty wrong");

  analog_duty_a: assert property (
    !setup_r[`FCSR_B_DSRC] && !vopen_r |-> duty_sel == vduty_r)
    else $error("analog duty not used");

  duty_filter_a: assert property (
    pin_s2_r[3:0] != vduty_prev_r |=> $stable(vduty_r))
    else $error("analog code taken before it settled");

  flags_top_a: assert property (
    reg_rd && reg_cmd == `FCSR_CMD_FLAGS |=> reg_rdata_r[7:6] == 2'b00)
    else $error("flags top bits not zero");

  flags_ro_a: assert property (
    reg_wr && reg_cmd == `FCSR_CMD_FLAGS |=> $stable(setup_r)
      && $stable(duty_r))
    else $error("flags write changed a register");

  ovf_two_a: assert property (
    raw[1] > `FCSR_SPEED_MAX |=> ovf_r[1])
    else $error("fan 2 overflow not set");

  ovf_back_a: assert property (
    raw[0] <= `FCSR_SPEED_MAX |=> !ovf_r[0])
    else $error("fan 1 overflow did not clear");

  fault_hold_a: assert property (
    flt_r[0] && !clr_pulse |=> flt_r[0])
    else $error("fan 1 fault cleared itself");

  alert_tie_a: assert property (
    qual[1] |=> flt_r[1] && !alert_n_r)
    else $error("fan 2 fault did not raise alert");

  capture_once_a: assert property (
    pu_r == PU_RUN |=> $stable(otf_r) && $stable(vopen_r))
    else $error("power-up flags changed after capture");

  ppr_decode_a: assert property (
    ##1 fan2_pulses_r == 4'h1 << $past(setup_r[4:3])
      && fan1_pulses_r == 4'h1 << $past(setup_r[2:1]))
    else $error("pulses per revolution decode wrong");

  repeat_clear_a: assert property (
    clr_pulse && setup_r[`FCSR_B_FCLR] && !(|qual) |=> flt_r == 2'b00)
    else $error("repeated clear ignored");

  shutdown_drive_a: assert property (
    setup_r[`FCSR_B_SHDN] [*2] |=> !pwm_drive_r)
    else $error("drive active in shutdown");

  fault_seen_c: cover property ($rose(flt_r[0]));
  clear_seen_c: cover property (flt_r[1] ##1 clr_pulse ##1 !flt_r[1]);
  shutdown_c:   cover property ($rose(shutdown_r));
  open_duty_c:  cover property (vopen_r && !setup_r[`FCSR_B_DSRC]);
endmodule

// >>> verification/fcsr_host.sv
// Purpose: Host side model issuing register reads and writes
// Assumes: Design samples strobes on the rising clock edge
// Notes:   gap adds idle cycles before each access
`timescale 1ns/1ns
module fcsr_host (
  input  wire logic       clk,
  output logic [7:0]      reg_cmd,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_r
);
  int gap = 0;

  initial begin
    reg_cmd   = 8'hff;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // ****************************************
  // Single byte accesses
  // ****************************************
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    reg_cmd   = cmd;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Released lines show no stale value
    reg_cmd   = ~cmd;
    reg_wdata = ~data;
  endtask

  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    reg_cmd = cmd;
    reg_rd  = 1'b1;
    @(negedge clk);
    reg_rd  = 1'b0;
    reg_cmd = ~cmd;
    @(negedge clk);
    data = reg_rdata_r;
  endtask
endmodule

// >>> verification/fan_control_status_regs_tb.sv
// Purpose: Self-checking bench for the fan register block
// Assumes: Fault window shortened to QUAL cycles
// Notes:   Expected values come from the bench model
`timescale 1ns/1ns
`include "fcsr_defs.svh"
module fan_control_status_regs_tb
  import fcsr_pkg::*;
;
  localparam int QUAL = 20;
  logic        clk, rst_b, over, vopen, wr, rd, pwm, alert_n, shdn;
  logic        over_cap, open_cap;
  logic [7:0]  cmd, wdata, rdata, thr1, thr2, rd_v;
  logic [8:0]  fan1_speed_reading, fan2_speed_reading;
  logic [3:0]  ppr1, ppr2;
  fcsr_duty_t  vduty;
  fcsr_raw_t   raw1, raw2;
  int          n_errors, check_count, setup_m, duty_m;
  int unsigned seed;

  fcsr_regs #(.FAULT_QUAL_CYCLES(QUAL)) fcsr_regs_i (
    .clk(clk), .rst_b(rst_b), .reg_cmd(cmd), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_r(rdata),
    .vin_over_pin(over), .vin_open_pin(vopen), .vin_duty_pin(vduty),
    .fan1_speed_raw(raw1), .fan2_speed_raw(raw2),
    .fan1_speed_threshold(thr1), .fan2_speed_threshold(thr2),
    .fan1_speed_reading_r(fan1_speed_reading), .fan2_speed_reading_r(fan2_speed_reading),
    .fan1_pulses_r(ppr1), .fan2_pulses_r(ppr2), .shutdown_r(shdn),
    .pwm_drive_r(pwm), .alert_n_r(alert_n)
  );

  fcsr_host fcsr_host_i (
    .clk(clk), .reg_cmd(cmd), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata_r(rdata)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Model and checks
  // ****************************************
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] flags_m(logic f2, logic f1);
    return {2'b00, over_cap, raw2 > 10'h1ff, raw1 > 10'h1ff, open_cap, f2, f1};
  endfunction

  task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_out(string n, logic [8:0] e, logic [8:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_cnt(string n, int e, int g);
    check_count++;
    if (g != e) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic rd_chk(logic [7:0] c, logic [7:0] e, string n);
    fcsr_host_i.read_reg(c, rd_v);
    chk_reg(n, e, rd_v);
  endtask

  task automatic wr_m(logic [7:0] c, logic [7:0] d);
    fcsr_host_i.write_reg(c, d);
    if (c == `FCSR_CMD_SETUP) setup_m = d;
    if (c == `FCSR_CMD_DUTY) duty_m = d[3:0];
  endtask

  task automatic pwm_chk(int e);
    int cnt;
    cnt = 0;
    repeat (300) @(negedge clk);
    repeat (300) begin
      @(negedge clk);
      if (pwm === 1'b1) cnt++;
    end
    chk_cnt("pwm high count", e, cnt);
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    over_cap = over;
    open_cap = vopen;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    setup_m = 8'h0a;
    duty_m = 2;
    repeat (2) @(negedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(20000 * 100);
    n_errors++;
    $display("watchdog expired");
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_b = 1'b0;
    over = 1'b1;
    vopen = 1'b1;
    vduty = 4'h9;
    raw1 = 10'd100;
    raw2 = 10'd100;
    thr1 = 8'h0a;
    thr2 = 8'h0a;
    n_errors = 0;
    check_count = 0;
    seed = 18;
    do_reset();
    rd_chk(`FCSR_CMD_SETUP, 8'h0a, "setup reset");
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 0), "flags reset");
    rd_chk(`FCSR_CMD_DUTY, 8'h02, "duty reset");
    rd_chk(8'h07, 8'h00, "unmapped");
    wr_m(`FCSR_CMD_FLAGS, 8'hff);
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 0), "flags ro");
    chk_out("shutdown", 9'h000, 9'(shdn));
    chk_out("alert", 9'h001, 9'(alert_n));
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr_m(`FCSR_CMD_SETUP, {3'b000, 2'(c), 2'(3 - c), 1'b0});
      @(negedge clk);
      chk_out("fan2 pulses", 9'(1 << c), 9'(ppr2));
      chk_out("fan1 pulses", 9'(1 << (3 - c)), 9'(ppr1));
      rd_chk(`FCSR_CMD_SETUP, 8'(setup_m), "setup");
    end
    wr_m(`FCSR_CMD_SETUP, 8'h0b);
    @(negedge clk);
    chk_out("shutdown", 9'h001, 9'(shdn));
    pwm_chk(0);
    $display("test setup done");
    fcsr_host_i.gap = 2;
    for (int r = 0; r < 2; r++) begin
      wr_m(`FCSR_CMD_SETUP, r ? 8'h4a : 8'h0a);
      repeat (16) begin
        raw1 = 10'(xs() % 1004 + 20);
        raw2 = 10'(xs() % 1004 + 20);
        repeat (2) @(negedge clk);
        if (raw1 <= 10'h1ff)
          chk_out("fan1_speed_reading", r ? raw1[8:0] : {1'b0, raw1[8:1]}, fan1_speed_reading);
        if (raw2 <= 10'h1ff)
          chk_out("fan2_speed_reading", r ? raw2[8:0] : {1'b0, raw2[8:1]}, fan2_speed_reading);
        rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 0), "overflow");
      end
    end
    fcsr_host_i.gap = 0;
    raw1 = 10'd100;
    raw2 = 10'd100;
    $display("test readings done");
    wr_m(`FCSR_CMD_SETUP, 8'h2a);
    for (int c = 0; c < 16; c += 5) begin
      wr_m(`FCSR_CMD_DUTY, 8'(c));
      rd_chk(`FCSR_CMD_DUTY, 8'(duty_m), "duty");
      pwm_chk(90 + 14 * duty_m);
    end
    wr_m(`FCSR_CMD_SETUP, 8'h0a);
    pwm_chk(90 + 14 * 2);
    $display("test duty done");
    raw1 = 10'd19;
    repeat (QUAL + 1) @(negedge clk);
    chk_out("alert early", 9'h001, 9'(alert_n));
    repeat (4) @(negedge clk);
    chk_out("alert fan1", 9'h000, 9'(alert_n));
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 1), "fault1");
    raw1 = 10'd100;
    repeat (30) @(negedge clk);
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 1), "fault held");
    wr_m(`FCSR_CMD_SETUP, 8'h8a);
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 0), "clear");
    chk_out("alert clear", 9'h001, 9'(alert_n));
    raw2 = 10'd0;
    repeat (QUAL + 5) @(negedge clk);
    chk_out("alert fan2", 9'h000, 9'(alert_n));
    rd_chk(`FCSR_CMD_FLAGS, flags_m(1, 0), "fault2");
    raw2 = 10'd100;
    wr_m(`FCSR_CMD_SETUP, 8'h8a);
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 0), "reclear");
    chk_out("alert reclear", 9'h001, 9'(alert_n));
    $display("test fault done");
    over = 1'b0;
    vopen = 1'b0;
    do_reset();
    rd_chk(`FCSR_CMD_FLAGS, flags_m(0, 0), "flags pins");
    pwm_chk(90 + 14 * 9);
    $display("test analog done");
    results();
  end
endmodule
